// ==== hdl/sfc_dev.sv ====
// Device end: configuration registers one, two and three behind the serial link.
`timescale 1ns/10ps
`include "sfc_regs.svh"
module sfc_dev
	import sfc_pkg::*;
#(
	parameter logic [7:0] VOL2_BOOT = `SFC_VOL2_RST
) (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Serial link
	sfc_link_if.dev         link,
	// Register contents
	output logic [7:0]      volatile_config_one,
	output logic [7:0]      volatile_config_two,
	output logic [7:0]      volatile_config_three,
	output logic [7:0]      boot_config_three,
	// Decoded controls
	output logic            blank_check_en,
	output logic            page_wrap_512,
	output logic            uniform_sectors,
	output logic            block_erase_256k,
	// Opcode 30h events
	output logic            clear_status_p,
	output logic            resume_p
);
	typedef struct packed {
		logic       sck_a;
		logic       sck_b;
		logic       sck_c;
		logic       cs_a;
		logic       cs_b;
		logic [3:0] io_a;
		logic [3:0] io_b;
		sfc_ph_t    ph;
		logic [5:0] cnt;
		logic [7:0] opc;
		logic [31:0] addr;
		logic [7:0] sh;
		sfc_cmd_t   cmd;
		logic [7:0] vol1;
		logic [7:0] vol2;
		logic [7:0] vol3;
		logic [7:0] boot3;
		logic [3:0] dout;
		logic [3:0] doe;
		logic       clr_p;
		logic       res_p;
	} sfc_dev_t;

	sfc_dev_t r;
	sfc_dev_t n;

	// Volatile state after a hardware or software reset.
	function automatic sfc_dev_t sfc_reload(sfc_dev_t s);
		s.vol1 = `SFC_VOL1_RST;
		s.vol2 = VOL2_BOOT;
		s.vol3 = s.boot3;
		s.ph = SFC_PH_IDLE;
		s.doe = 4'h0;
		return s;
	endfunction : sfc_reload

	function automatic sfc_cmd_t sfc_decode(logic [7:0] op, logic [7:0] cr2);
		sfc_cmd_t c;
		c.qopc = cr2[`SFC_CR2_QINS];
		c.qio = cr2[`SFC_CR2_QINS] || (op == `SFC_OP_QIO);
		c.a4 = cr2[`SFC_CR2_ALEN];
		c.has_addr = 1'b1;
		c.mode = 3'h0;
		c.dummy = {2'h0, cr2[3:0]};
		c.dir = SFC_DIR_RD;
		case (op)
			`SFC_OP_READ: c.dummy = 6'h00;
			`SFC_OP_FAST, `SFC_OP_RD_ANY: ;
			`SFC_OP_QIO:  c.mode = `SFC_MODE_QIO;
			`SFC_OP_WR_ANY: begin
				c.dummy = 6'h00;
				c.dir = SFC_DIR_WR;
			end
			`SFC_OP_SFDP: begin
				c.a4 = 1'b0;
				c.dummy = `SFC_DUMMY_SFDP;
			end
			`SFC_OP_UID: begin
				c.has_addr = 1'b0;
				c.dummy = `SFC_DUMMY_UID;
			end
			default: begin
				c.has_addr = 1'b0;
				c.dummy = 6'h00;
				c.dir = SFC_DIR_NONE;
			end
		endcase
		return c;
	endfunction : sfc_decode

	function automatic logic [7:0] sfc_rd_val(logic [7:0] op, logic [31:0] a,
		sfc_dev_t s);
		logic [7:0] v;
		v = `SFC_RD_FILL;
		if (op == `SFC_OP_RD_ANY) begin
			case (a)
				`SFC_RA_VOL1:  v = s.vol1;
				`SFC_RA_VOL2:  v = s.vol2;
				`SFC_RA_VOL3:  v = s.vol3;
				`SFC_RA_BOOT3: v = s.boot3;
				default:       v = 8'h00;
			endcase
		end
		return v;
	endfunction : sfc_rd_val

	logic        rise;
	logic        fall;
	logic        q;
	logic        last;
	logic [31:0] t;
	logic [7:0]  wd;

	assign rise = r.sck_b && !r.sck_c;
	assign fall = !r.sck_b && r.sck_c;
	assign q = sfc_quad(r.ph, r.cmd);

	always_comb begin
		n = r;
		t = 32'h0000_0000;
		wd = 8'h00;
		last = 1'b0;
		n.sck_a = link.sck;
		n.sck_b = r.sck_a;
		n.sck_c = r.sck_b;
		n.cs_a = link.cs_n;
		n.cs_b = r.cs_a;
		n.io_a = link.io;
		n.io_b = r.io_a;
		n.clr_p = 1'b0;
		n.res_p = 1'b0;
		if (r.vol2[`SFC_CR2_IO3R] && !r.io_b[3] &&
			(r.cs_b || !r.vol1[`SFC_CR1_QUAD])) begin
			n = sfc_reload(n);
		end else if (r.cs_b) begin
			n.ph = SFC_PH_IDLE;
			n.doe = 4'h0;
		end else if (r.ph == SFC_PH_IDLE) begin
			n.ph = SFC_PH_OPC;
			n.cnt = 6'h00;
			n.opc = 8'h00;
			n.addr = 32'h0000_0000;
			n.cmd = sfc_decode(8'h00, r.vol2);
		end else if (rise && r.ph != SFC_PH_DONE) begin
			case (r.ph)
				SFC_PH_OPC: begin
					t = sfc_shin({24'h0, r.opc}, q, r.io_b);
					n.opc = t[7:0];
				end
				SFC_PH_ADDR: n.addr = sfc_shin(r.addr, q, r.io_b);
				SFC_PH_DATA: if (r.cmd.dir == SFC_DIR_WR) begin
					t = sfc_shin({24'h0, r.sh}, q, r.io_b);
					n.sh = t[7:0];
				end
				default: ;
			endcase
			last = (r.cnt == sfc_clks(r.ph, r.cmd) - 6'h01);
			n.cnt = last ? 6'h00 : r.cnt + 6'h01;
			if (last) begin
				n.ph = sfc_next(r.ph, r.cmd);
				if (r.ph == SFC_PH_OPC) begin
					n.cmd = sfc_decode(n.opc, r.vol2);
					n.ph = sfc_next(SFC_PH_OPC, n.cmd);
					case (n.opc)
						`SFC_OP_ADDR4: n.vol2[`SFC_CR2_ALEN] = 1'b1;
						`SFC_OP_SRST: if (r.vol3[`SFC_CR3_F0]) begin
							n = sfc_reload(n);
							n.ph = SFC_PH_DONE;
						end
						`SFC_OP_30H: begin
							n.res_p = r.vol3[`SFC_CR3_RES];
							n.clr_p = !r.vol3[`SFC_CR3_RES];
						end
						default: ;
					endcase
				end else if (r.ph == SFC_PH_DATA) begin
					if (r.cmd.dir == SFC_DIR_RD) begin
						n.ph = SFC_PH_DATA;
					end else begin
						wd = n.sh;
						case (r.addr)
							`SFC_RA_VOL1: n.vol1 = wd;
							`SFC_RA_VOL2: begin
								n.vol2 = wd;
								if (wd[`SFC_CR2_QINS]) begin
									n.vol1[`SFC_CR1_QUAD] = 1'b1;
								end
							end
							`SFC_RA_VOL3: begin
								n.vol3 = wd & `SFC_CR3_MASK;
								n.vol3[`SFC_CR3_UNI] = r.boot3[`SFC_CR3_UNI];
							end
							`SFC_RA_BOOT3:
								n.boot3 = r.boot3 | (wd & `SFC_CR3_MASK);
							default: ;
						endcase
					end
				end
				if (n.ph == SFC_PH_DATA && n.cmd.dir == SFC_DIR_RD) begin
					n.sh = sfc_rd_val(n.opc, n.addr, r);
				end
			end
		end else if (fall && r.ph == SFC_PH_DATA && r.cmd.dir == SFC_DIR_RD)
			begin
			if (q) begin
				n.dout = r.sh[7:4];
				n.doe = 4'hF;
				n.sh = {r.sh[3:0], 4'h0};
			end else begin
				n.dout = {2'h0, r.sh[7], 1'b0};
				n.doe = 4'h2;
				n.sh = {r.sh[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
			r.sck_a <= 1'b0;
			r.cs_a <= 1'b1;
			r.cs_b <= 1'b1;
			r.io_a <= 4'hF;
			r.io_b <= 4'hF;
			r.ph <= SFC_PH_IDLE;
			r.vol1 <= `SFC_VOL1_RST;
			r.vol2 <= VOL2_BOOT;
			r.vol3 <= `SFC_BOOT3_RST;
			r.boot3 <= `SFC_BOOT3_RST;
		end else begin
			r <= n;
		end
	end

	assign link.d_o = r.dout;
	assign link.d_oe = r.doe;
	assign volatile_config_one = r.vol1;
	assign volatile_config_two = r.vol2;
	assign volatile_config_three = r.vol3;
	assign boot_config_three = r.boot3;
	assign blank_check_en = r.vol3[`SFC_CR3_BC];
	assign page_wrap_512 = r.vol3[`SFC_CR3_WRAP];
	assign uniform_sectors = r.vol3[`SFC_CR3_UNI];
	assign block_erase_256k = r.vol3[`SFC_CR3_BLK];
	assign clear_status_p = r.clr_p;
	assign resume_p = r.res_p;
endmodule : sfc_dev

// ==== hdl/sfc_host.sv ====
// Host end: APB-programmed controller that issues one serial command.
`timescale 1ns/10ps
`include "sfc_regs.svh"
module sfc_host
	import sfc_pkg::*;
#(
	parameter int HALF = `SFC_SCK_HALF
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Serial link
	sfc_link_if.host         link
);
	// Slower serial clocks are allowed; faster ones are not.
	localparam int HALF_EFF = (HALF < `SFC_SCK_HALF_MIN) ?
		`SFC_SCK_HALF_MIN : HALF;

	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] addr;
		logic [7:0]  wd;
		logic [7:0]  rd;
		logic        busy;
		sfc_ph_t     ph;
		sfc_cmd_t    cmd;
		logic [5:0]  cnt;
		logic [7:0]  div;
		logic        sck;
		logic        cs_n;
		logic [31:0] sh;
		logic [3:0]  o;
		logic [3:0]  oe;
		logic [3:0]  io_a;
		logic [3:0]  io_b;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} sfc_host_t;

	sfc_host_t r;
	sfc_host_t n;

	function automatic sfc_cmd_t sfc_to_cmd(logic [31:0] c);
		sfc_cmd_t k;
		k.qopc = c[`SFC_C_QOPC];
		k.qio = c[`SFC_C_QIO];
		k.a4 = c[`SFC_C_A4];
		k.has_addr = c[`SFC_C_HASA];
		k.mode = c[14:12];
		k.dummy = c[21:16];
		k.dir = sfc_dir_t'(c[23:22]);
		return k;
	endfunction : sfc_to_cmd

	// Puts the next bits of the shift register on the lines.
	function automatic sfc_host_t sfc_drive(sfc_host_t s);
		logic q;
		q = sfc_quad(s.ph, s.cmd);
		if (s.ph == SFC_PH_DUMMY || s.ph == SFC_PH_DONE ||
			(s.ph == SFC_PH_DATA && s.cmd.dir == SFC_DIR_RD)) begin
			s.oe = 4'h0;
		end else if (q) begin
			s.o = s.sh[31:28];
			s.oe = 4'hF;
			s.sh = {s.sh[27:0], 4'h0};
		end else begin
			s.o = {3'h0, s.sh[31]};
			s.oe = 4'h1;
			s.sh = {s.sh[30:0], 1'b0};
		end
		return s;
	endfunction : sfc_drive

	logic tick;
	logic last;
	logic map_ok;

	assign tick = (r.div == 8'(HALF_EFF - 1));
	assign map_ok = (paddr == `SFC_A_CTRL) || (paddr == `SFC_A_ADDR) ||
		(paddr == `SFC_A_WDATA) || (paddr == `SFC_A_RDATA) ||
		(paddr == `SFC_A_STAT);

	always_comb begin
		n = r;
		last = 1'b0;
		n.io_a = link.io;
		n.io_b = r.io_a;
		if (psel && !penable && !r.pready) begin
			n.pready = 1'b1;
			n.pslverr = !map_ok;
			case (paddr)
				`SFC_A_CTRL:  n.prdata = r.ctrl;
				`SFC_A_ADDR:  n.prdata = r.addr;
				`SFC_A_WDATA: n.prdata = {24'h0, r.wd};
				`SFC_A_RDATA: n.prdata = {24'h0, r.rd};
				`SFC_A_STAT:  n.prdata = {31'h0, r.busy};
				default:      n.prdata = 32'h0000_0000;
			endcase
		end else if (psel && penable && r.pready) begin
			n.pready = 1'b0;
			n.pslverr = 1'b0;
			if (pwrite && !r.busy) begin
				case (paddr)
					`SFC_A_ADDR:  n.addr = pwdata;
					`SFC_A_WDATA: n.wd = pwdata[7:0];
					`SFC_A_CTRL: begin
						n.ctrl = pwdata;
						n.ctrl[`SFC_C_START] = 1'b0;
						if (pwdata[`SFC_C_START]) begin
							n.busy = 1'b1;
							n.cs_n = 1'b0;
							n.div = 8'h00;
							n.cnt = 6'h00;
							n.ph = SFC_PH_OPC;
							n.cmd = sfc_to_cmd(pwdata);
							n.sh = {pwdata[7:0], 24'h0};
							n = sfc_drive(n);
						end
					end
					default: ;
				endcase
			end
		end
		if (r.busy) begin
			n.div = tick ? 8'h00 : r.div + 8'h01;
			if (tick && r.ph == SFC_PH_DONE) begin
				// The last rise is followed by a fall as select goes high.
				n.sck = 1'b0;
				n.oe = 4'h0;
				n.cs_n = 1'b1;
				if (r.cs_n) begin
					n.busy = 1'b0;
					n.ph = SFC_PH_IDLE;
				end
			end else if (tick && !r.sck) begin
				n.sck = 1'b1;
				if (r.ph == SFC_PH_DATA && r.cmd.dir == SFC_DIR_RD) begin
					n.rd = r.cmd.qio ? {r.rd[3:0], r.io_b} :
						{r.rd[6:0], r.io_b[1]};
				end
				last = (r.cnt == sfc_clks(r.ph, r.cmd) - 6'h01);
				n.cnt = last ? 6'h00 : r.cnt + 6'h01;
				if (last) begin
					n.ph = sfc_next(r.ph, r.cmd);
					case (n.ph)
						SFC_PH_ADDR: n.sh = r.cmd.a4 ? r.addr : {r.addr[23:0], 8'h0};
						SFC_PH_DATA: n.sh = {r.wd, 24'h0};
						default:     n.sh = 32'h0000_0000;
					endcase
				end
			end else if (tick) begin
				n.sck = 1'b0;
				n = sfc_drive(n);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
			r.ph <= SFC_PH_IDLE;
			r.cs_n <= 1'b1;
			r.io_a <= 4'hF;
			r.io_b <= 4'hF;
		end else begin
			r <= n;
		end
	end

	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign link.sck = r.sck;
	assign link.cs_n = r.cs_n;
	assign link.h_o = r.o;
	assign link.h_oe = r.oe;
endmodule : sfc_host

// ==== hdl/sfc_link_if.sv ====
// Serial flash link between the host controller and the device.
`timescale 1ns/10ps
interface sfc_link_if;
	logic       sck;
	logic       cs_n;
	logic [3:0] h_o;
	logic [3:0] h_oe;
	logic [3:0] d_o;
	logic [3:0] d_oe;
	logic [3:0] io;

	// Undriven lines are pulled high.
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			io[i] = h_oe[i] ? h_o[i] : (d_oe[i] ? d_o[i] : 1'b1);
		end
	end

	modport host (output sck, output cs_n, output h_o, output h_oe,
		input io);
	modport dev (input sck, input cs_n, input io, output d_o, output d_oe);
endinterface : sfc_link_if

// ==== hdl/sfc_pkg.sv ====
// Shared types and phase arithmetic for both ends of the serial link.
package sfc_pkg;
	typedef enum logic [2:0] {
		SFC_PH_IDLE  = 3'h0,
		SFC_PH_OPC   = 3'h1,
		SFC_PH_ADDR  = 3'h3,
		SFC_PH_MODE  = 3'h2,
		SFC_PH_DUMMY = 3'h6,
		SFC_PH_DATA  = 3'h7,
		SFC_PH_DONE  = 3'h5
	} sfc_ph_t;
	typedef enum logic [1:0] {
		SFC_DIR_NONE = 2'h0,
		SFC_DIR_WR   = 2'h1,
		SFC_DIR_RD   = 2'h2
	} sfc_dir_t;
	typedef struct packed {
		logic       qopc;
		logic       qio;
		logic       has_addr;
		logic       a4;
		logic [2:0] mode;
		logic [5:0] dummy;
		sfc_dir_t   dir;
	} sfc_cmd_t;

	function automatic logic sfc_quad(sfc_ph_t p, sfc_cmd_t c);
		return (p == SFC_PH_OPC) ? c.qopc : c.qio;
	endfunction : sfc_quad

	// Serial clocks that a phase lasts; zero means the phase is skipped.
	function automatic logic [5:0] sfc_clks(sfc_ph_t p, sfc_cmd_t c);
		logic [5:0] k;
		k = 6'h00;
		case (p)
			SFC_PH_OPC:   k = c.qopc ? 6'h02 : 6'h08;
			SFC_PH_ADDR:  if (c.has_addr) begin
				k = c.qio ? (c.a4 ? 6'h08 : 6'h06) : (c.a4 ? 6'h20 : 6'h18);
			end
			SFC_PH_MODE:  k = {3'h0, c.mode};
			SFC_PH_DUMMY: k = c.dummy;
			SFC_PH_DATA:  if (c.dir != SFC_DIR_NONE) begin
				k = c.qio ? 6'h02 : 6'h08;
			end
			default:      k = 6'h00;
		endcase
		return k;
	endfunction : sfc_clks

	function automatic sfc_ph_t sfc_next(sfc_ph_t p, sfc_cmd_t c);
		sfc_ph_t s;
		logic    found;
		s = p;
		found = 1'b0;
		for (int i = 0; i < 5; i++) begin
			if (!found) begin
				case (s)
					SFC_PH_OPC:   s = SFC_PH_ADDR;
					SFC_PH_ADDR:  s = SFC_PH_MODE;
					SFC_PH_MODE:  s = SFC_PH_DUMMY;
					SFC_PH_DUMMY: s = SFC_PH_DATA;
					default:      s = SFC_PH_DONE;
				endcase
				found = (s == SFC_PH_DONE) || (sfc_clks(s, c) != 6'h00);
			end
		end
		return s;
	endfunction : sfc_next

	function automatic logic [31:0] sfc_shin(logic [31:0] v, logic q,
		logic [3:0] io);
		return q ? {v[27:0], io} : {v[30:0], io[0]};
	endfunction : sfc_shin
endpackage : sfc_pkg

// ==== hdl/sfc_regs.svh ====
// Opcodes, register addresses, field positions, reset values and timing.
`ifndef SFC_REGS_SVH
`define SFC_REGS_SVH
`define SFC_OP_READ      8'h03
`define SFC_OP_FAST      8'h0B
`define SFC_OP_QIO       8'hEB
`define SFC_OP_RD_ANY    8'h65
`define SFC_OP_WR_ANY    8'h71
`define SFC_OP_ADDR4     8'hB7
`define SFC_OP_SFDP      8'h5A
`define SFC_OP_UID       8'h4B
`define SFC_OP_SRST      8'hF0
`define SFC_OP_30H       8'h30
`define SFC_RA_VOL1      32'h0000_0001
`define SFC_RA_VOL2      32'h0000_0002
`define SFC_RA_VOL3      32'h0000_0003
`define SFC_RA_BOOT3     32'h0000_0004
`define SFC_CR1_QUAD     1
`define SFC_CR2_ALEN     7
`define SFC_CR2_QINS     6
`define SFC_CR2_IO3R     5
`define SFC_CR3_BC       5
`define SFC_CR3_WRAP     4
`define SFC_CR3_UNI      3
`define SFC_CR3_RES      2
`define SFC_CR3_BLK      1
`define SFC_CR3_F0       0
`define SFC_VOL1_RST     8'h00
`define SFC_VOL2_RST     8'h08
`define SFC_BOOT3_RST    8'h00
`define SFC_CR3_MASK     8'h3F
`define SFC_RD_FILL      8'hFF
`define SFC_MODE_QIO     3'h2
`define SFC_DUMMY_SFDP   6'h08
`define SFC_DUMMY_UID    6'h20
`define SFC_PCLK_MHZ     20
`define SFC_SCK_MAX_MHZ  133
`define SFC_SCK_HALF_MIN \
	((`SFC_PCLK_MHZ + 2 * `SFC_SCK_MAX_MHZ - 1) / (2 * `SFC_SCK_MAX_MHZ))
`define SFC_SCK_HALF     8
`define SFC_A_CTRL       12'h000
`define SFC_A_ADDR       12'h004
`define SFC_A_WDATA      12'h008
`define SFC_A_RDATA      12'h00C
`define SFC_A_STAT       12'h010
`define SFC_C_QOPC       8
`define SFC_C_QIO        9
`define SFC_C_A4         10
`define SFC_C_HASA       11
`define SFC_C_START      31
`endif

// ==== verif/sfc_link_asserts.sv ====
// Concurrent checks on the serial link between the host and device ends.
`timescale 1ns/10ps
module sfc_link_asserts #(
	parameter int HALF = 8
) (
	// Clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// Link signals
	input wire logic       sck,
	input wire logic       cs_n,
	input wire logic [3:0] h_o,
	input wire logic [3:0] h_oe,
	input wire logic [3:0] d_o,
	input wire logic [3:0] d_oe
);
	logic       sck_r;
	logic [7:0] hcnt_r;
	logic [5:0] rises_r;

	// Counts cycles since the last clock edge and rises within a frame.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_r   <= 1'b0;
			hcnt_r  <= 8'h00;
			rises_r <= 6'h00;
		end else begin
			sck_r   <= sck;
			hcnt_r  <= (sck != sck_r) ? 8'h00 : hcnt_r + 8'h01;
			if (cs_n) begin
				rises_r <= 6'h00;
			end else if (sck && !sck_r && rises_r != 6'h3F) begin
				rises_r <= rises_r + 6'h01;
			end
		end
	end

	default clocking dc @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence cs_held_s;
		cs_n [*8];
	endsequence
	sequence hold_s(sig);
		$stable(sig) [*3];
	endsequence

	sck_idle_a: assert property (cs_n |-> !sck)
		else $error("serial clock high outside a frame");
	sck_rise_a: assert property ($rose(sck) |-> !cs_n)
		else $error("serial clock rose with select high");
	sck_half_a: assert property ((sck_r && !sck) |-> hcnt_r == 8'(HALF - 1))
		else $error("serial clock high phase has wrong length");
	line_own_a: assert property ((h_oe & d_oe) == 4'h0)
		else $error("both ends drive one line");
	dev_release_a: assert property ($rose(cs_n) |-> ##[0:3] d_oe == 4'h0)
		else $error("device still drives after deselect");
	dev_quiet_a: assert property (cs_held_s |-> d_oe == 4'h0)
		else $error("device drives while deselected");
	cs_gap_a: assert property ($rose(cs_n) |-> cs_held_s)
		else $error("select high time too short");
	dev_wait_a: assert property ((d_oe != 4'h0 && !cs_n) |-> rises_r >= 6'h02)
		else $error("device drove before the opcode ended");
	dev_hold_a: assert property (($rose(sck) && d_oe != 4'h0) |=> hold_s(d_o))
		else $error("device data moved after a rising clock");
	host_hold_a: assert property (($rose(sck) && h_oe != 4'h0) |=> hold_s(h_o))
		else $error("host data moved after a rising clock");
endmodule : sfc_link_asserts

// ==== verif/sfc_regs_tb.sv ====
// Self-checking bench joining host and device ends over the link.
`timescale 1ns/10ps
`include "sfc_regs.svh"
module sfc_regs_tb;
	localparam int HALF = `SFC_SCK_HALF;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  vc1;
	logic [7:0]  vc2;
	logic [7:0]  vc3;
	logic [7:0]  bc3;
	logic [3:0]  dec;
	logic        clr_p;
	logic        res_p;
	logic [31:0] rd;
	logic        err;
	logic [31:0] fix_rd [4];
	int          n_errors;
	int          tests_run;
	int          n_clr;
	int          n_res;

	sfc_link_if link ();

	sfc_host #(.HALF(HALF)) u_sfc_host (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link(link.host)
	);
	sfc_dev u_sfc_dev (
		.pclk(pclk), .presetn(presetn), .link(link.dev),
		.volatile_config_one(vc1), .volatile_config_two(vc2),
		.volatile_config_three(vc3), .boot_config_three(bc3),
		.blank_check_en(dec[3]), .page_wrap_512(dec[2]),
		.uniform_sectors(dec[1]), .block_erase_256k(dec[0]),
		.clear_status_p(clr_p), .resume_p(res_p)
	);
	sfc_link_asserts #(.HALF(HALF)) u_sfc_link_asserts (
		.pclk(pclk), .presetn(presetn), .sck(link.sck), .cs_n(link.cs_n),
		.h_o(link.h_o), .h_oe(link.h_oe), .d_o(link.d_o), .d_oe(link.d_oe)
	);

	always #25 pclk = ~pclk;

	always @(posedge pclk) begin
		if (clr_p === 1'b1) n_clr++;
		if (res_p === 1'b1) n_res++;
	end

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : complete_run

	task automatic check(input string what, input logic [7:0] exp, got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i >= 50) begin
			n_errors++;
			complete_run();
		end
		@(posedge pclk);
	endtask : apb

	task automatic cmd(input logic [31:0] ctl, a, input logic [7:0] d);
		int i;
		apb(1'b1, `SFC_A_ADDR, a);
		apb(1'b1, `SFC_A_WDATA, {24'h000000, d});
		apb(1'b1, `SFC_A_CTRL, ctl | 32'h80000000);
		i = 0;
		do begin
			apb(1'b0, `SFC_A_STAT, 32'h0);
			i++;
		end while (rd[0] !== 1'b0 && i < 900);
		if (i >= 900) begin
			n_errors++;
			complete_run();
		end
		apb(1'b0, `SFC_A_RDATA, 32'h0);
	endtask : cmd

	function automatic logic [31:0] cw(logic [7:0] op, logic qo, qi, a4,
		ha, logic [2:0] m, logic [5:0] dm, logic [1:0] dir);
		return {8'h00, dir, dm, 1'b0, m, ha, a4, qi, qo, op};
	endfunction : cw

	task automatic read_any(input logic [31:0] r, input logic q, a4,
		input logic [5:0] dm);
		cmd(cw(`SFC_OP_RD_ANY, q, q, a4, 1'b1, 3'h0, dm, 2'h2), r, 8'h00);
	endtask : read_any

	task automatic write_any(input logic [31:0] r, input logic [7:0] v,
		input logic q, a4);
		cmd(cw(`SFC_OP_WR_ANY, q, q, a4, 1'b1, 3'h0, 6'h00, 2'h1), r, v);
	endtask : write_any

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		n_errors = 0;
		tests_run = 0;
		n_clr = 0;
		n_res = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		check("vol2 reset", 8'h08, vc2);
		check("boot3 reset", 8'h00, bc3);
		check("vol3 reset", 8'h00, vc3);
		check("decoded reset", 8'h00, {4'h0, dec});
		read_any(`SFC_RA_VOL2, 1'b0, 1'b0, 6'h08);
		check("read vol2", 8'h08, rd[7:0]);
		apb(1'b0, 12'h020, 32'h0);
		check("unmapped", 8'h01, {7'h00, err});
		$display("test reset_values done");
		write_any(`SFC_RA_VOL2, 8'h03, 1'b0, 1'b0);
		check("vol2 latency", 8'h03, vc2);
		read_any(`SFC_RA_VOL2, 1'b0, 1'b0, 6'h03);
		check("read latency 3", 8'h03, rd[7:0]);
		cmd(cw(`SFC_OP_ADDR4, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 6'h00, 2'h0),
			32'h0, 8'h00);
		check("four byte set", 8'h83, vc2);
		read_any(`SFC_RA_VOL2, 1'b0, 1'b1, 6'h03);
		check("read 4 byte", 8'h83, rd[7:0]);
		$display("test latency_addr done");
		write_any(`SFC_RA_VOL2, 8'hC3, 1'b0, 1'b1);
		check("quad enable set", 8'h01, {7'h00, vc1[1]});
		read_any(`SFC_RA_VOL2, 1'b1, 1'b1, 6'h03);
		check("quad read", 8'hC3, rd[7:0]);
		write_any(`SFC_RA_VOL2, 8'h03, 1'b1, 1'b1);
		read_any(`SFC_RA_VOL1, 1'b0, 1'b0, 6'h03);
		check("quad enable kept", 8'h02, rd[7:0]);
		$display("test quad done");
		write_any(`SFC_RA_BOOT3, 8'hFF, 1'b0, 1'b0);
		check("boot3 program", 8'h3F, bc3);
		write_any(`SFC_RA_BOOT3, 8'h00, 1'b0, 1'b0);
		read_any(`SFC_RA_BOOT3, 1'b0, 1'b0, 6'h03);
		check("boot3 no erase", 8'h3F, rd[7:0]);
		cmd(cw(`SFC_OP_SRST, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 6'h00, 2'h0),
			32'h0, 8'h00);
		check("reset ignored", 8'h00, vc3);
		write_any(`SFC_RA_VOL3, 8'h01, 1'b0, 1'b0);
		check("vol3 bit3 kept", 8'h09, vc3);
		cmd(cw(`SFC_OP_SRST, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 6'h00, 2'h0),
			32'h0, 8'h00);
		check("vol3 reload", 8'h3F, vc3);
		check("decoded", 8'h0F, {4'h0, dec});
		$display("test boot_three done");
		cmd(cw(`SFC_OP_30H, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 6'h00, 2'h0),
			32'h0, 8'h00);
		check("30h resume", 8'h10, {4'(n_res), 4'(n_clr)});
		write_any(`SFC_RA_VOL3, 8'h3B, 1'b0, 1'b0);
		cmd(cw(`SFC_OP_30H, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 6'h00, 2'h0),
			32'h0, 8'h00);
		check("30h clear", 8'h11, {4'(n_res), 4'(n_clr)});
		$display("test opcode_30h done");
		fix_rd = '{cw(`SFC_OP_SFDP, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 6'h08, 2'h2),
			cw(`SFC_OP_UID, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 6'h20, 2'h2),
			cw(`SFC_OP_QIO, 1'b0, 1'b1, 1'b0, 1'b1, 3'h2, 6'h08, 2'h2),
			cw(`SFC_OP_READ, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 6'h00, 2'h2)};
		foreach (fix_rd[k]) begin
			cmd(fix_rd[k], 32'h0, 8'h00);
			check("fixed read", `SFC_RD_FILL, rd[7:0]);
		end
		$display("test fixed_reads done");
		complete_run();
	end
endmodule : sfc_regs_tb
